// ==== core/msrbs_pkg.sv ====
// Purpose: Constants for the motor start, run and brake sequencer
// Assumes: AHB-Lite word registers, 20 MHz hclk
// Notes on behaviour
// (RL1) Forward spin, no brake: drive or ramp by threshold
// (RL2) Reverse with brake select: brake, recheck, idle
// (RL3) Reverse, no brake: decelerate, then restart opposite
// (RL4) Locate method: 1 detection, 0 alignment
// (RL5) Detection: half-plane pulses, then polarity test
// (RL6) Waveform 0: DC current for alignment duration
// (RL7) Waveform 1: open-loop spin at reciprocal frequency
// (RL8) Detection failure falls back to alignment
// (RL9) Locate done: go to open-loop acceleration
// (RL10) Ramp frequency to target, then closed loop
// (RL11) Configure handover above 35 Hz
// (RL12) Drive caps Q current and its slew rates
// (RL13) Drive optionally slews the speed command
// (RL14) Regeneration limits pump-up or regen current
// (RL15) Brake pulses all low sides on/off
// (RL16) Overspeed: coast until brake is allowed
// (RL17) Brake on pin, control bit or coast-check
// (RL18) Command off: brake and hold, or idle
// (RL19) Gentle stop decelerates in drive state
// (RL20) Drive estimates angle and speed sensorlessly
// (RL21) Stopped or illegal sequence: locate rotor
// (RL22) Idle leaves on command above on-threshold
// (RL23) Any brake source forces brake next cycle
package msrbs_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CMD     = 8'h04;
    localparam logic [7:0] ADDR_THR     = 8'h08;
    localparam logic [7:0] ADDR_ALIGN   = 8'h0C;
    localparam logic [7:0] ADDR_RAMP    = 8'h10;
    localparam logic [7:0] ADDR_QLIM    = 8'h14;
    localparam logic [7:0] ADDR_REGEN   = 8'h18;
    localparam logic [7:0] ADDR_BRAKE   = 8'h1C;
    localparam logic [7:0] ADDR_MEAS    = 8'h20;
    localparam logic [7:0] ADDR_STATUS  = 8'h24;
    localparam logic [7:0] ADDR_DRIVE   = 8'h28;
    // ==========================================================
    // Control register bit positions
    localparam int CTRL_BRAKE      = 0;
    localparam int CTRL_ALWAYS_BRK = 1;
    localparam int CTRL_REV_BRK    = 2;
    localparam int CTRL_LOCATE     = 3;
    localparam int CTRL_WAVE       = 4;
    localparam int CTRL_FALLBACK   = 5;
    localparam int CTRL_HALT_OFF   = 6;
    localparam int CTRL_GENTLE     = 7;
    localparam int CTRL_SLEW_EN    = 8;
    localparam int CTRL_PUMP_MODE  = 9;
    localparam logic [9:0] CTRL_RESET = 10'h020;
    // ==========================================================
    // Reset values of parameter registers
    localparam logic [31:0] THR_RESET   = 32'h0010_0020;
    localparam logic [31:0] ALIGN_RESET = 32'h0100_0400;
    localparam logic [31:0] RAMP_RESET  = 32'h0001_0800;
    localparam logic [31:0] QLIM_RESET  = 32'h0010_1000;
    localparam logic [31:0] REGEN_RESET = 32'h0010_0800;
    localparam logic [31:0] BRAKE_RESET = 32'h0100_0040;
    // Test pulse length of detection stage 1, in cycles; stage 2 ends on detect_done
    localparam logic [15:0] DETECT_STAGE_CYC = 16'h0100;
    localparam int          ANGLE_STEP_DEG = 30;
    // ==========================================================
    typedef enum logic [2:0] {
        MSRBS_IDLE, MSRBS_COAST, MSRBS_LOCATE, MSRBS_ALIGN,
        MSRBS_ACCEL, MSRBS_DRIVE, MSRBS_BRAKE
    } msrbs_state_e;
endpackage

// ==== core/msrbs_top.sv ====
// Purpose: Start, run and brake sequencer with AHB-Lite registers
// Assumes: Measured speed, direction and detect results come from the observer
// Notes: Power stage is tri-state in idle unless low sides are held after a halted stop; all outputs registered
`timescale 1ns/1ps
`default_nettype none
module msrbs_top #(
    parameter int W = 16
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          stop_request_pin_n,
    input  wire logic [W-1:0]  motor_speed_abs,
    input  wire logic          motor_reverse,
    input  wire logic          illegal_sequence,
    input  wire logic          detect_done,
    input  wire logic          detect_fail,
    input  wire logic [2:0]    detect_sector,
    input  wire logic          supply_over_thr,
    input  wire logic          regen_active,
    output logic      [2:0]    low_side_on,
    output logic               bridge_enable,
    output logic      [1:0]    detect_stage,
    output logic               dc_inject,
    output logic      [W-1:0]  drive_freq,
    output logic      [W-1:0]  current_ref,
    output logic      [W-1:0]  speed_ref,
    output logic      [8:0]    rotor_angle,
    output logic               observer_enable,
    output logic      [2:0]    seq_state
);
    typedef struct packed {
        logic [9:0]  ctrl;
        logic [31:0] cmd, thr, align, ramp, qlim, regen, brk;
        logic [7:0]  addr;
        logic        wr, rd;
        logic [31:0] rdata;
        msrbs_pkg::msrbs_state_e st;
        logic        reversed, hold;
        logic [15:0] cnt;
        logic [15:0] pcnt;
        logic        pon;
        logic [W-1:0] freq, iq, sref;
        logic [2:0]  ls;
        logic        en, dci, obs;
        logic [1:0]  stage;
        logic [8:0]  ang;
    } msrbs_s;
    msrbs_s s_r, s_nxt;

    // Move value toward target by at most step
    function automatic logic [W-1:0] slew(input logic [W-1:0] cur, input logic [W-1:0] tgt,
                                          input logic [W-1:0] up, input logic [W-1:0] dn);
        logic [W:0] t;
        t = '0;
        if (tgt > cur) begin
            t = {1'b0, cur} + {1'b0, up};
            slew = (t > {1'b0, tgt}) ? tgt : t[W-1:0];
        end else begin
            slew = (cur - tgt > dn) ? cur - dn : tgt;
        end
    endfunction

    logic [W-1:0] cmd_v, on_th, off_th, stop_th, obs_th, ovs_th;
    logic         brake_req, cmd_off;
    assign cmd_v   = s_r.cmd[W-1:0];
    assign on_th   = s_r.thr[W-1:0];
    assign off_th  = s_r.thr[31:16];
    assign stop_th = s_r.ramp[31:16];
    assign obs_th  = s_r.qlim[31:16];
    assign ovs_th  = s_r.regen[31:16];
    assign cmd_off = cmd_v < off_th;
    // Brake sources combined; any one forces brake (see RL17) (see RL23)
    assign brake_req = !stop_request_pin_n || s_r.ctrl[msrbs_pkg::CTRL_BRAKE];

    // ==========================================================
    // Next state: bus slave and sequencer
    always_comb begin
        logic [W-1:0] itgt;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
        itgt = '0;
        rise = '0;
        fall = '0;
        s_nxt = s_r;
        // AHB-Lite address phase capture, zero wait states
        s_nxt.wr = hsel && hready && htrans[1] && hwrite;
        s_nxt.rd = hsel && hready && htrans[1] && !hwrite;
        if (hsel && hready && htrans[1]) s_nxt.addr = haddr[7:0];
        if (s_r.wr) begin
            case (s_r.addr)
                msrbs_pkg::ADDR_CTRL:  s_nxt.ctrl  = hwdata[9:0];
                msrbs_pkg::ADDR_CMD:   s_nxt.cmd   = {16'h0000, hwdata[15:0]};
                msrbs_pkg::ADDR_THR:   s_nxt.thr   = hwdata;
                msrbs_pkg::ADDR_ALIGN: s_nxt.align = hwdata;
                msrbs_pkg::ADDR_RAMP:  s_nxt.ramp  = hwdata;
                msrbs_pkg::ADDR_QLIM:  s_nxt.qlim  = hwdata;
                msrbs_pkg::ADDR_REGEN: s_nxt.regen = hwdata;
                msrbs_pkg::ADDR_BRAKE: s_nxt.brk   = hwdata;
                default: ;
            endcase
        end
        case (haddr[7:0])
            msrbs_pkg::ADDR_CTRL:   s_nxt.rdata = {22'h000000, s_r.ctrl};
            msrbs_pkg::ADDR_CMD:    s_nxt.rdata = s_r.cmd;
            msrbs_pkg::ADDR_THR:    s_nxt.rdata = s_r.thr;
            msrbs_pkg::ADDR_ALIGN:  s_nxt.rdata = s_r.align;
            msrbs_pkg::ADDR_RAMP:   s_nxt.rdata = s_r.ramp;
            msrbs_pkg::ADDR_QLIM:   s_nxt.rdata = s_r.qlim;
            msrbs_pkg::ADDR_REGEN:  s_nxt.rdata = s_r.regen;
            msrbs_pkg::ADDR_BRAKE:  s_nxt.rdata = s_r.brk;
            msrbs_pkg::ADDR_MEAS:   s_nxt.rdata = {16'h0000, motor_speed_abs};
            msrbs_pkg::ADDR_STATUS: s_nxt.rdata = {20'h00000, s_r.ang, s_r.st};
            msrbs_pkg::ADDR_DRIVE:  s_nxt.rdata = {s_r.iq, s_r.freq};
            default:                s_nxt.rdata = 32'h0000_0000;
        endcase

        // Sequencer defaults
        s_nxt.ls  = 3'h0;
        s_nxt.dci = 1'b0;
        s_nxt.obs = 1'b0;
        s_nxt.cnt = s_r.cnt + 16'h0001;
        case (s_r.st)
            msrbs_pkg::MSRBS_IDLE: begin
                s_nxt.en = 1'b0;
                s_nxt.freq = '0;
                s_nxt.iq = '0;
                s_nxt.sref = '0;
                if (s_r.hold) s_nxt.ls = 3'h7; // Hold low sides after halted stop
                if (brake_req) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE;
                end else if (cmd_v > on_th) begin // see RL22
                    s_nxt.st = msrbs_pkg::MSRBS_COAST;
                    s_nxt.hold = 1'b0;
                end
            end
            msrbs_pkg::MSRBS_COAST: begin
                s_nxt.en = 1'b0;
                s_nxt.cnt = 16'h0000;
                if (brake_req) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE;
                end else if (s_r.reversed && motor_speed_abs < stop_th) begin
                    s_nxt.st = msrbs_pkg::MSRBS_IDLE; // see RL2
                    s_nxt.reversed = 1'b0;
                end else if (cmd_off) begin
                    s_nxt.st = msrbs_pkg::MSRBS_IDLE;
                end else if (motor_speed_abs < stop_th || illegal_sequence) begin
                    // see RL21 (see RL4)
                    s_nxt.st = s_r.ctrl[msrbs_pkg::CTRL_LOCATE] ? msrbs_pkg::MSRBS_LOCATE
                                                                 : msrbs_pkg::MSRBS_ALIGN;
                    s_nxt.stage = 2'h1;
                end else if (s_r.ctrl[msrbs_pkg::CTRL_ALWAYS_BRK] ||
                             (motor_reverse && s_r.ctrl[msrbs_pkg::CTRL_REV_BRK])) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE; // see RL2
                    s_nxt.reversed = 1'b1;
                end else if (motor_reverse) begin
                    // Decelerate under closed loop to zero, then restart (see RL3)
                    s_nxt.st = msrbs_pkg::MSRBS_DRIVE;
                    s_nxt.reversed = 1'b1;
                    s_nxt.freq = motor_speed_abs;
                end else begin
                    // see RL1
                    s_nxt.st = (motor_speed_abs >= obs_th) ? msrbs_pkg::MSRBS_DRIVE
                                                           : msrbs_pkg::MSRBS_ACCEL;
                    s_nxt.freq = motor_speed_abs;
                end
            end
            msrbs_pkg::MSRBS_LOCATE: begin
                // Two stages; stage 2 starts after stage 1 test pulses (see RL5)
                s_nxt.en = 1'b1;
                if (brake_req) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE;
                end else if (detect_fail) begin
                    s_nxt.st = s_r.ctrl[msrbs_pkg::CTRL_FALLBACK] ? msrbs_pkg::MSRBS_ALIGN
                                                                   : msrbs_pkg::MSRBS_IDLE; // see RL8
                    s_nxt.cnt = 16'h0000;
                    s_nxt.stage = 2'h0;
                end else if (s_r.stage == 2'h1 && s_r.cnt >= msrbs_pkg::DETECT_STAGE_CYC) begin
                    s_nxt.stage = 2'h2;
                    s_nxt.cnt = 16'h0000;
                end else if (s_r.stage == 2'h2 && detect_done) begin
                    s_nxt.ang = 9'(32'(detect_sector) * msrbs_pkg::ANGLE_STEP_DEG);
                    s_nxt.st = msrbs_pkg::MSRBS_ACCEL; // see RL9
                    s_nxt.stage = 2'h0;
                    s_nxt.cnt = 16'h0000;
                    s_nxt.freq = '0;
                end
            end
            msrbs_pkg::MSRBS_ALIGN: begin
                s_nxt.en = 1'b1;
                s_nxt.iq = s_r.align[W-1:0]; // Current limited to reference
                if (s_r.ctrl[msrbs_pkg::CTRL_WAVE]) begin
                    s_nxt.freq = W'(1); // One turn per duration (see RL7)
                end else begin
                    s_nxt.dci = 1'b1; // see RL6
                    s_nxt.freq = '0;
                end
                if (brake_req) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE;
                end else if (s_r.cnt >= s_r.align[31:16]) begin
                    s_nxt.st = msrbs_pkg::MSRBS_ACCEL; // see RL9
                    s_nxt.cnt = 16'h0000;
                    s_nxt.freq = '0;
                end
            end
            msrbs_pkg::MSRBS_ACCEL: begin
                // Open-loop frequency ramp (see RL10)
                s_nxt.en = 1'b1;
                s_nxt.iq = s_r.ramp[W-1:0];
                s_nxt.freq = slew(s_r.freq, s_r.brk[31:16], s_r.regen[15:0] >> 4, '0);
                if (brake_req) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE; // see RL23
                end else if (cmd_off) begin
                    s_nxt.st = msrbs_pkg::MSRBS_IDLE;
                end else if (s_r.cnt >= s_r.align[15:0] || s_r.freq >= s_r.brk[31:16]) begin
                    s_nxt.st = msrbs_pkg::MSRBS_DRIVE;
                    s_nxt.sref = s_r.freq;
                end
            end
            msrbs_pkg::MSRBS_DRIVE: begin
                s_nxt.en = 1'b1;
                s_nxt.obs = 1'b1; // Sensorless estimator active (see RL20)
                // Speed reference slew (see RL13)
                if (s_r.reversed || (cmd_off && s_r.ctrl[msrbs_pkg::CTRL_GENTLE]))
                    itgt = '0;
                else
                    itgt = cmd_v;
                s_nxt.sref = s_r.ctrl[msrbs_pkg::CTRL_SLEW_EN]
                           ? slew(s_r.sref, itgt, W'(s_r.thr[31:24]), W'(s_r.thr[31:24])) : itgt;
                s_nxt.freq = s_nxt.sref;
                // Q current limits; regen alternative (see RL12) (see RL14)
                rise = W'(s_r.qlim[7:0]);
                fall = W'(s_r.qlim[15:8]);
                itgt = (s_nxt.sref > s_r.sref) ? s_r.qlim[15:0] : s_r.iq;
                if (regen_active) begin
                    if (s_r.ctrl[msrbs_pkg::CTRL_PUMP_MODE]) begin
                        if (supply_over_thr) itgt = '0;
                    end else begin
                        if (itgt > s_r.regen[15:0]) itgt = s_r.regen[15:0];
                        rise = W'(s_r.regen[7:0]);
                        fall = W'(s_r.regen[7:0]);
                    end
                end
                if (itgt > s_r.qlim[15:0]) itgt = s_r.qlim[15:0];
                s_nxt.iq = slew(s_r.iq, itgt, rise, fall);
                if (brake_req) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE; // see RL23
                end else if (s_r.reversed && s_r.freq == '0) begin
                    s_nxt.st = msrbs_pkg::MSRBS_COAST; // Restart from stop (see RL3)
                    s_nxt.reversed = 1'b0;
                end else if (cmd_off && s_r.ctrl[msrbs_pkg::CTRL_HALT_OFF]) begin
                    s_nxt.st = msrbs_pkg::MSRBS_BRAKE; // see RL18
                    s_nxt.hold = 1'b1;
                end else if (cmd_off && !s_r.ctrl[msrbs_pkg::CTRL_GENTLE]) begin
                    s_nxt.st = msrbs_pkg::MSRBS_IDLE; // see RL18
                end else if (cmd_off && s_r.freq == '0) begin
                    s_nxt.st = msrbs_pkg::MSRBS_IDLE; // see RL19
                end
            end
            msrbs_pkg::MSRBS_BRAKE: begin
                s_nxt.en = 1'b1;
                s_nxt.iq = '0;
                s_nxt.freq = '0;
                if (motor_speed_abs > ovs_th) begin
                    s_nxt.pcnt = 16'h0000; // Coast until slow enough (see RL16)
                    s_nxt.pon = 1'b1;
                end else begin
                    // Pulsed low-side pattern (see RL15)
                    s_nxt.ls = s_r.pon ? 3'h7 : 3'h0;
                    s_nxt.pcnt = s_r.pcnt + 16'h0001;
                    // Zero-length intervals still last one cycle
                    if (s_r.pon && s_r.pcnt + 16'h0001 >= 16'(s_r.brk[7:0])) begin
                        s_nxt.pon = 1'b0;
                        s_nxt.pcnt = 16'h0000;
                    end else if (!s_r.pon && s_r.pcnt + 16'h0001 >= 16'(s_r.brk[15:8])) begin
                        s_nxt.pon = 1'b1;
                        s_nxt.pcnt = 16'h0000;
                    end
                end
                if (!brake_req && motor_speed_abs < stop_th) begin
                    s_nxt.st = s_r.reversed ? msrbs_pkg::MSRBS_COAST : msrbs_pkg::MSRBS_IDLE;
                end
            end
            default: s_nxt.st = msrbs_pkg::MSRBS_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.ctrl <= msrbs_pkg::CTRL_RESET;
            s_r.thr <= msrbs_pkg::THR_RESET;
            s_r.align <= msrbs_pkg::ALIGN_RESET;
            s_r.ramp <= msrbs_pkg::RAMP_RESET;
            s_r.qlim <= msrbs_pkg::QLIM_RESET;
            s_r.regen <= msrbs_pkg::REGEN_RESET;
            s_r.brk <= msrbs_pkg::BRAKE_RESET;
            s_r.pon <= 1'b1;
            s_r.st <= msrbs_pkg::MSRBS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flops
    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign low_side_on = s_r.ls;
    assign bridge_enable = s_r.en;
    assign detect_stage = s_r.stage;
    assign dc_inject = s_r.dci;
    assign drive_freq = s_r.freq;
    assign current_ref = s_r.iq;
    assign speed_ref = s_r.sref;
    assign rotor_angle = s_r.ang;
    assign observer_enable = s_r.obs;
    assign seq_state = s_r.st;

    // ==========================================================
    // Assertions
    AST_BRAKE_PIN: assert property (@(posedge hclk) disable iff (!hresetn) // see RL23
        (!stop_request_pin_n && s_r.st inside {msrbs_pkg::MSRBS_DRIVE, msrbs_pkg::MSRBS_ACCEL})
        |=> s_r.st == msrbs_pkg::MSRBS_BRAKE) else $error("Brake pin not honoured");
    AST_BRAKE_BIT: assert property (@(posedge hclk) disable iff (!hresetn) // see RL17
        (s_r.ctrl[msrbs_pkg::CTRL_BRAKE] && s_r.st == msrbs_pkg::MSRBS_DRIVE)
        |=> s_r.st == msrbs_pkg::MSRBS_BRAKE) else $error("Brake bit not honoured");
    AST_IDLE_ON: assert property (@(posedge hclk) disable iff (!hresetn) // see RL22
        (s_r.st == msrbs_pkg::MSRBS_IDLE && !brake_req && cmd_v > on_th)
        |=> s_r.st == msrbs_pkg::MSRBS_COAST) else $error("Idle did not leave");
    AST_LOCATE_SEL: assert property (@(posedge hclk) disable iff (!hresetn) // see RL4
        (s_r.st == msrbs_pkg::MSRBS_COAST && $changed(s_r.st) == 0 && s_nxt.st ==
         msrbs_pkg::MSRBS_LOCATE) |-> s_r.ctrl[msrbs_pkg::CTRL_LOCATE])
        else $error("Wrong locate method");
    AST_FALLBACK: assert property (@(posedge hclk) disable iff (!hresetn) // see RL8
        (s_r.st == msrbs_pkg::MSRBS_LOCATE && !brake_req && detect_fail &&
         s_r.ctrl[msrbs_pkg::CTRL_FALLBACK]) |=> s_r.st == msrbs_pkg::MSRBS_ALIGN)
        else $error("No alignment fallback");
    AST_DC_INJ: assert property (@(posedge hclk) disable iff (!hresetn) // see RL6
        s_r.dci |-> ($past(s_r.st) == msrbs_pkg::MSRBS_ALIGN &&
                     !$past(s_r.ctrl[msrbs_pkg::CTRL_WAVE])))
        else $error("DC injection outside alignment");
    AST_LOW_IDLE: assert property (@(posedge hclk) disable iff (!hresetn) // see RL15
        (s_r.ls != 3'h0) |-> ($past(s_r.st) inside {msrbs_pkg::MSRBS_BRAKE, msrbs_pkg::MSRBS_IDLE}))
        else $error("Low sides on outside brake");
    AST_QCAP: assert property (@(posedge hclk) disable iff (!hresetn) // see RL12
        (s_r.st == msrbs_pkg::MSRBS_DRIVE) |=> (s_r.iq <= $past(s_r.qlim[15:0])))
        else $error("Q current above ceiling");
    AST_OBS: assert property (@(posedge hclk) disable iff (!hresetn) // see RL20
        s_r.obs |-> $past(s_r.st) == msrbs_pkg::MSRBS_DRIVE) else $error("Observer outside drive");
    COV_DRIVE: cover property (@(posedge hclk) s_r.st == msrbs_pkg::MSRBS_DRIVE);
    COV_BRAKE: cover property (@(posedge hclk) s_r.st == msrbs_pkg::MSRBS_BRAKE && s_r.ls == 3'h7);
    COV_ALIGN: cover property (@(posedge hclk) s_r.st == msrbs_pkg::MSRBS_ALIGN);
    COV_LOCATE: cover property (@(posedge hclk)
        s_r.st == msrbs_pkg::MSRBS_LOCATE && s_r.stage == 2'h2);
    AST_ALIGN_DONE: assert property (@(posedge hclk) disable iff (!hresetn) // see RL9
        (s_r.st == msrbs_pkg::MSRBS_ALIGN && !brake_req && s_r.cnt >= s_r.align[31:16])
        |=> s_r.st == msrbs_pkg::MSRBS_ACCEL) else $error("Alignment did not hand over");
    AST_COAST_FWD: assert property (@(posedge hclk) disable iff (!hresetn) // see RL1
        (s_r.st == msrbs_pkg::MSRBS_COAST && !brake_req && !s_r.reversed && !cmd_off &&
         !illegal_sequence && !motor_reverse && motor_speed_abs >= stop_th &&
         !s_r.ctrl[msrbs_pkg::CTRL_ALWAYS_BRK])
        |=> s_r.st inside {msrbs_pkg::MSRBS_DRIVE, msrbs_pkg::MSRBS_ACCEL})
        else $error("Forward spin not resumed");
endmodule
`default_nettype wire

// ==== test/msrbs_motor.sv ====
// Purpose: Motor and power bridge stand-in
// Assumes: Speed follows drive frequency, coasts down slowly
// Notes: Detection answers once stage two is applied
`timescale 1ns/1ps
`default_nettype none
module msrbs_motor (
    input  wire logic        hclk,
    input  wire logic [2:0]  low_side_on,
    input  wire logic        bridge_enable,
    input  wire logic [15:0] drive_freq,
    input  wire logic [1:0]  detect_stage,
    output logic      [15:0] speed,
    output logic             done
);
    // ==========================================
    // Zero frequency, shorted windings or coasting slow the rotor
    initial speed = 16'h0;
    initial done = 1'b0;
    always @(posedge hclk) begin
        if (bridge_enable && drive_freq != 16'h0) speed <= drive_freq;
        else if (speed != 16'h0) speed <= speed - 16'h1;
        done <= (detect_stage == 2'h2);
    end
endmodule
`default_nettype wire

// ==== test/msrbs_top_tb.sv ====
// Purpose: Self-checking bench for the sequencer
// Assumes: Zero-wait slave, reset register values
// Notes: Reads are checked through an expectation queue
`timescale 1ns/1ps
`default_nettype none
module msrbs_top_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_due;
    logic stop_request_pin_n, motor_reverse, illegal_sequence, detect_done;
    logic detect_fail, supply_over_thr, regen_active, bridge_enable;
    logic dc_inject, observer_enable;
    logic [31:0] haddr, hwdata, hrdata, lf, q[$];
    logic [1:0]  htrans, detect_stage;
    logic [2:0]  hsize, detect_sector, low_side_on, seq_state;
    logic [15:0] motor_speed_abs, drive_freq, current_ref, speed_ref;
    logic [8:0]  rotor_angle;
    int          miscompares, total_checks, on_n, off_n;
    msrbs_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .stop_request_pin_n(stop_request_pin_n), .motor_speed_abs(motor_speed_abs),
        .motor_reverse(motor_reverse), .illegal_sequence(illegal_sequence),
        .detect_done(detect_done), .detect_fail(detect_fail), .detect_sector(detect_sector),
        .supply_over_thr(supply_over_thr), .regen_active(regen_active),
        .low_side_on(low_side_on), .bridge_enable(bridge_enable), .detect_stage(detect_stage),
        .dc_inject(dc_inject), .drive_freq(drive_freq), .current_ref(current_ref),
        .speed_ref(speed_ref), .rotor_angle(rotor_angle), .observer_enable(observer_enable),
        .seq_state(seq_state));
    msrbs_motor mot_u (.hclk(hclk), .low_side_on(low_side_on),
        .bridge_enable(bridge_enable), .drive_freq(drive_freq),
        .detect_stage(detect_stage), .speed(motor_speed_abs), .done(detect_done));
    // ==========================================
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Next value of the random source
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Single AHB-Lite transfer, held until hreadyout
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_due <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_due <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic go(input logic [2:0] s, input int lim);
        for (int n = 0; n < lim && seq_state !== s; n++) @(posedge hclk);
        chk("state", seq_state, s);
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Read data checked in the data phase against the oldest note
    always @(negedge hclk) if (rd_due) begin
        chk("hrdata", hrdata, q.pop_front());
        chk("hresp", hresp, 1'b0);
    end
    // Watchdog
    initial begin
        #2000000;
        miscompares++;
        wrap_up();
    end
    // ==========================================
    initial begin
        {hresetn, hsel, hwrite, rd_due, motor_reverse, illegal_sequence} = 6'h0;
        {detect_fail, supply_over_thr, regen_active} = 3'h0;
        {haddr, hwdata, htrans} = 66'h0;
        {hsize, hready, stop_request_pin_n, detect_sector} = 8'h5A;
        {miscompares, total_checks, lf} = {32'h0, 32'h0, 32'h4F};
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(msrbs_pkg::ADDR_CTRL, {22'h0, msrbs_pkg::CTRL_RESET});
        rd(msrbs_pkg::ADDR_BRAKE, msrbs_pkg::BRAKE_RESET);
        rd(8'h30, 32'h0);
        lf = lfsr(lf);
        bus(msrbs_pkg::ADDR_CMD, 1'b1, {lf[31:16], 12'h0, lf[3:0]});
        rd(msrbs_pkg::ADDR_CMD, {28'h0, lf[3:0]});
        bus(msrbs_pkg::ADDR_CMD, 1'b1, 32'h100);
        go(msrbs_pkg::MSRBS_COAST, 4);
        go(msrbs_pkg::MSRBS_ALIGN, 8);
        @(posedge hclk);
        chk("dc", dc_inject, 1'b1);
        go(msrbs_pkg::MSRBS_ACCEL, 300);
        go(msrbs_pkg::MSRBS_DRIVE, 3000);
        @(posedge hclk);
        chk("observer", observer_enable, 1'b1);
        chk("speed_ref", speed_ref, 32'h100);
        chk("current_ref", current_ref, msrbs_pkg::RAMP_RESET[15:0]);
        bus(msrbs_pkg::ADDR_CMD, 1'b1, 32'h0);
        go(msrbs_pkg::MSRBS_IDLE, 8);
        bus(msrbs_pkg::ADDR_CMD, 1'b1, 32'h100);
        go(msrbs_pkg::MSRBS_DRIVE, 12);
        stop_request_pin_n <= 1'b0;
        go(msrbs_pkg::MSRBS_BRAKE, 2);
        {on_n, off_n} = 64'h0;
        repeat (600) begin
            @(posedge hclk);
            if (low_side_on === 3'h7) begin
                chk("coast", motor_speed_abs > msrbs_pkg::REGEN_RESET[31:16], 1'b0);
                on_n++;
            end
            if (low_side_on === 3'h0 && on_n > 0) off_n++;
        end
        chk("pulsed", (on_n > 0) && (off_n > 0), 1'b1);
        stop_request_pin_n <= 1'b1;
        bus(msrbs_pkg::ADDR_CMD, 1'b1, 32'h0);
        bus(msrbs_pkg::ADDR_CTRL, 1'b1, 32'h21);
        go(msrbs_pkg::MSRBS_BRAKE, 4);
        bus(msrbs_pkg::ADDR_CTRL, 1'b1, 32'h28);
        go(msrbs_pkg::MSRBS_IDLE, 2000);
        for (int n = 0; n < 600 && motor_speed_abs != 16'h0; n++) @(posedge hclk);
        bus(msrbs_pkg::ADDR_CMD, 1'b1, 32'h100);
        go(msrbs_pkg::MSRBS_LOCATE, 10);
        go(msrbs_pkg::MSRBS_ACCEL, 1500);
        chk("angle", rotor_angle, 9'h03C);
        wrap_up();
    end
endmodule
`default_nettype wire
